// File: hdl/sdm_monitor.sv
// safe direction monitor for one drive axis, plain-port configuration
// assumes position words and system tick are on clk; activation pin is not
//
// What this block does
// - monitor-only variant never requests a braking stop, only drops acknowledge.
// - permanent mode monitors continuously, ignoring activation input and on-delay.
// - input activation starts monitoring after the on-delay, 0 to 120000 ms.
// - a partial-cycle on-delay ends at the next system cycle boundary.
// - configuration selects first or second axis; first is default.
// - while monitoring, movement direction is compared with the permitted direction.
// - permitted motion drags the window reference along; it never accumulates.
// - reverse movement beyond the window from the reference triggers error reaction.
// - clockwise is positive; permitted direction default is negative.
// - tolerance window spans 0 to 2147483647 increments, default 100.
// - full variant requests braking stop on the axis and drops acknowledge.
// - activation input is low active: 0 activates, 1 deactivates.
// - acknowledge is 1 within limits, 0 on violation or when inactive.
// - in the full variant, the braking stop request starts on every monitored limit violation.
`timescale 1ns/1ps
`include "sdm_params.svh"

module sdm_monitor
    import sdm_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `SDM_CYC_PER_MS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire sdm_cfg_t cfg,
    // system cycle boundary and axis feedback
    input wire logic sys_tick,
    input wire sdm_pos_t pos,
    // safe input pin
    input wire logic activation_input_n,
    // safe outputs
    output logic direction_ack,
    output sdm_stop_t braking_stop_function
);

    // ----------------------------------------------------------------
    // reset release and pin synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_n;
    logic act_meta_reg;
    logic act_n_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // deactivated until the pin is seen, so reset never looks like activation
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            act_meta_reg <= 1'b1;
            act_n_reg <= 1'b1;
        end
        else
        begin
            act_meta_reg <= activation_input_n;
            act_n_reg <= act_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // direction arithmetic
    // ----------------------------------------------------------------
    // distance moved against the permitted direction, signed, one guard bit
    function automatic logic signed [`SDM_POS_W:0] rev_dist(
        input logic [`SDM_POS_W-1:0] now_pos,
        input logic [`SDM_POS_W-1:0] ref_pos,
        input sdm_dir_t dir
    );
        logic signed [`SDM_POS_W:0] d;
        d = $signed({now_pos[`SDM_POS_W-1], now_pos}) - $signed({ref_pos[`SDM_POS_W-1], ref_pos});
        rev_dist = (dir == SDM_DIR_POSITIVE) ? -d : d;
    endfunction

    logic [`SDM_POS_W-1:0] pos_sel;
    logic signed [`SDM_POS_W:0] rev;
    logic active;
    logic viol;
    logic drag;

    assign pos_sel = (cfg.axis == SDM_SECOND_AXIS) ? pos.second_axis : pos.first_axis;
    assign active = cfg.permanent || !act_n_reg;

    // ----------------------------------------------------------------
    // monitor state
    // ----------------------------------------------------------------
    sdm_state_t state_reg, state_next;
    logic [`SDM_POS_W-1:0] ref_reg, ref_next;
    logic [`SDM_PRE_W-1:0] pre_reg, pre_next;
    logic [`SDM_DLY_W-1:0] ms_reg, ms_next;
    logic ack_reg, ack_next;
    sdm_stop_t stop_reg, stop_next;

    assign rev = rev_dist(pos_sel, ref_reg, cfg.permitted_dir);
    assign viol = rev > $signed({2'b00, cfg.tol_win});
    assign drag = rev < 0;

    always_comb
    begin
        state_next = state_reg;
        ref_next = ref_reg;
        pre_next = pre_reg;
        ms_next = ms_reg;
        stop_next = stop_reg;
        case (state_reg)
            SDM_IDLE:
            begin
                pre_next = '0;
                ms_next = '0;
                stop_next = '0;
                if (cfg.permanent)
                begin
                    state_next = SDM_MONITOR;
                    ref_next = pos_sel;
                end
                else if (active)
                    state_next = SDM_DELAY;
            end
            SDM_DELAY:
            begin
                // whole milliseconds; a delay ending mid cycle waits for the tick
                if (ms_reg < cfg.on_delay_ms)
                begin
                    if (pre_reg == `SDM_PRE_W'(CYC_PER_MS - 1))
                    begin
                        pre_next = '0;
                        ms_next = ms_reg + 1'b1;
                    end
                    else
                        pre_next = pre_reg + 1'b1;
                end
                else if (sys_tick)
                begin
                    state_next = SDM_MONITOR;
                    ref_next = pos_sel;
                end
            end
            SDM_MONITOR:
            begin
                if (sys_tick)
                begin
                    if (viol)
                    begin
                        state_next = SDM_FAULT;
                        if (!cfg.monitor_only_direction_variant)
                        begin
                            stop_next.first_axis = (cfg.axis == SDM_FIRST_AXIS);
                            stop_next.second_axis = (cfg.axis == SDM_SECOND_AXIS);
                        end
                    end
                    else if (drag)
                        ref_next = pos_sel;
                end
            end
            SDM_FAULT:
            begin
                // held until deactivation; in permanent mode until cfg.permanent is cleared with the pin at 1
            end
            default:
                state_next = SDM_IDLE;
        endcase
        if (!active)
            state_next = SDM_IDLE;
        ack_next = (state_next == SDM_MONITOR);
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg <= SDM_IDLE;
            ref_reg <= '0;
            pre_reg <= '0;
            ms_reg <= '0;
            ack_reg <= 1'b0;
            stop_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            ref_reg <= ref_next;
            pre_reg <= pre_next;
            ms_reg <= ms_next;
            ack_reg <= ack_next;
            stop_reg <= stop_next;
        end
    end

    assign direction_ack = ack_reg;
    assign braking_stop_function = stop_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_mon_only_no_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_MONITOR && sys_tick && viol && cfg.monitor_only_direction_variant)
        |=> (stop_reg == '0) && !direction_ack;
    endproperty
    a_mon_only_no_stop: assert property (p_mon_only_no_stop) else $error("stop in monitor-only");

    property p_permanent_start;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_IDLE && cfg.permanent) |=> (state_reg == SDM_MONITOR) && direction_ack;
    endproperty
    a_permanent_start: assert property (p_permanent_start) else $error("permanent not at once");

    property p_no_early_start;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_DELAY && state_next == SDM_MONITOR) |-> ms_reg >= cfg.on_delay_ms;
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("on-delay cut short");

    property p_start_on_tick;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_DELAY) ##1 (state_reg == SDM_MONITOR) |-> $past(sys_tick);
    endproperty
    a_start_on_tick: assert property (p_start_on_tick) else $error("start off cycle boundary");

    property p_axis_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(stop_reg.second_axis) |-> $past(cfg.axis == SDM_SECOND_AXIS) && !stop_reg.first_axis;
    endproperty
    a_axis_stop: assert property (p_axis_stop) else $error("stop on wrong axis");

    property p_drag_ref;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_MONITOR && sys_tick && drag && active) |=> ref_reg == $past(pos_sel);
    endproperty
    a_drag_ref: assert property (p_drag_ref) else $error("reference not dragged");

    property p_viol_fault;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_MONITOR && sys_tick && viol && active)
        |=> (state_reg == SDM_FAULT) && !direction_ack;
    endproperty
    a_viol_fault: assert property (p_viol_fault) else $error("violation missed");

    property p_full_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        (state_reg == SDM_MONITOR && sys_tick && viol && active
            && !cfg.monitor_only_direction_variant)
        |=> (stop_reg != '0) ##1 (stop_reg != '0 || state_reg == SDM_IDLE);
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("braking stop missing");

    property p_inactive_idle;
        @(posedge clk) disable iff (!rst_sync_n)
        (act_n_reg && !cfg.permanent) |=> (state_reg == SDM_IDLE) && !direction_ack;
    endproperty
    a_inactive_idle: assert property (p_inactive_idle) else $error("active while deactivated");

    property p_ack_state;
        @(posedge clk) disable iff (!rst_sync_n)
        direction_ack |-> (state_reg == SDM_MONITOR);
    endproperty
    a_ack_state: assert property (p_ack_state) else $error("ack outside monitoring");

endmodule // sdm_monitor

// File: hdl/sdm_params.svh
// constants of the safe direction monitor
// assumes a 125 MHz clock and one system cycle tick from the surrounding logic
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SDM_POS_W 32
`define SDM_TOL_W 31
`define SDM_DLY_W 17
`define SDM_PRE_W 17

// ----------------------------------------------------------------
// configuration limits and defaults
// ----------------------------------------------------------------
`define SDM_ON_DELAY_MAX_MS 17'd120000
`define SDM_ON_DELAY_DEF_MS 17'd20
`define SDM_TOL_MAX 31'h7fffffff
`define SDM_TOL_DEF 31'd100

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDM_CLK_PERIOD_NS 8
`define SDM_MS_NS 1000000
`define SDM_CYC_PER_MS (`SDM_MS_NS / `SDM_CLK_PERIOD_NS)

`endif

// File: hdl/sdm_pkg.sv
// types shared by the safe direction monitor
// assumes sdm_params.svh is on the include path
`include "sdm_params.svh"

package sdm_pkg;

    typedef enum logic {SDM_FIRST_AXIS = 1'b0, SDM_SECOND_AXIS = 1'b1} sdm_axis_t;
    typedef enum logic {SDM_DIR_NEGATIVE = 1'b0, SDM_DIR_POSITIVE = 1'b1} sdm_dir_t;

    typedef struct packed {
        logic permanent;
        logic monitor_only_direction_variant;
        sdm_axis_t axis;
        sdm_dir_t permitted_dir;
        logic [`SDM_DLY_W-1:0] on_delay_ms;
        logic [`SDM_TOL_W-1:0] tol_win;
    } sdm_cfg_t;

    typedef struct packed {
        logic [`SDM_POS_W-1:0] first_axis;
        logic [`SDM_POS_W-1:0] second_axis;
    } sdm_pos_t;

    typedef struct packed {
        logic first_axis;
        logic second_axis;
    } sdm_stop_t;

    typedef enum logic [1:0] {SDM_IDLE, SDM_DELAY, SDM_MONITOR, SDM_FAULT} sdm_state_t;

endpackage

// File: verif/sdm_axis_model.sv
// stand-in for the drive axis: two position feedbacks and the system cycle tick
// assumes the bench moves the axes with move_axis at the falling clock edge
`timescale 1ns/1ps
module sdm_axis_model
    import sdm_pkg::*;
#(
    parameter int TICK_CYC = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // feedback to the monitor
    output logic sys_tick,
    output sdm_pos_t pos
);
    int cnt;

    initial
    begin
        pos = '0;
    end

    // ------------------------------------------------------------
    // tick period not a whole number of ms, so on-delays end mid-cycle
    // ------------------------------------------------------------
    always @(negedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            sys_tick <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
            sys_tick <= (cnt == TICK_CYC - 1);
        end
    end

    // the other axis swings the opposite way, four times as far
    task automatic move_axis(input logic ax, input int d);
        if (ax == 1'b0)
        begin
            pos.first_axis = 32'(int'(pos.first_axis) + d);
            pos.second_axis = 32'(int'(pos.second_axis) - 4 * d);
        end
        else
        begin
            pos.second_axis = 32'(int'(pos.second_axis) + d);
            pos.first_axis = 32'(int'(pos.first_axis) - 4 * d);
        end
    endtask
endmodule // sdm_axis_model

// File: verif/sdm_monitor_test.sv
// self-checking bench of the safe direction monitor
// assumes sdm_pkg and the axis model are compiled first
`timescale 1ns/1ps
module sdm_monitor_test
    import sdm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic activation_input_n = 1'b1;
    sdm_cfg_t cfg = '0;
    logic sys_tick;
    sdm_pos_t pos;
    logic direction_ack;
    sdm_stop_t braking_stop_function;
    int miscompares = 0;
    int total_checks = 0;
    integer seed = 12354;
    // integer model of the watched axis
    int m_pos, m_ref, m_tol, m_dir, m_ax, m_mo;
    bit m_fault;

    always #4 clk = ~clk;

    sdm_axis_model i_sdm_axis_model (.clk(clk), .rst_n(rst_n), .sys_tick(sys_tick), .pos(pos));
    sdm_monitor #(.CYC_PER_MS(4)) i_sdm_monitor (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .sys_tick(sys_tick), .pos(pos), .activation_input_n(activation_input_n),
        .direction_ack(direction_ack), .braking_stop_function(braking_stop_function));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // move the watched axis, let two system cycles pass, compare with the model
    // ------------------------------------------------------------
    task automatic step(input string what, input int d);
        int rev;
        int exp_stop;
        i_sdm_axis_model.move_axis(m_ax[0], d);
        m_pos = m_pos + d;
        rev = (m_dir != 0) ? m_ref - m_pos : m_pos - m_ref;
        if (rev > m_tol)
            m_fault = 1'b1;
        else if (rev < 0 && !m_fault)
            m_ref = m_pos;
        exp_stop = (m_fault && m_mo == 0) ? ((m_ax != 0) ? 1 : 2) : 0;
        cyc(12);
        check({what, " ack"}, direction_ack, !m_fault);
        check({what, " stop"}, braking_stop_function, exp_stop);
    endtask

    // ------------------------------------------------------------
    // one activation, drag, window edge, violation and release
    // ------------------------------------------------------------
    task automatic run_pass(input int ax, input int dir, input int mo);
        int tol;
        int s;
        int n;
        tol = ($random(seed) & 15) + 3;
        s = dir ? 1 : -1; // clockwise counts up
        cfg.monitor_only_direction_variant = mo[0];
        cfg.axis = sdm_axis_t'(ax[0]);
        cfg.permitted_dir = sdm_dir_t'(dir[0]);
        cfg.on_delay_ms = 17'h2;
        cfg.tol_win = 31'(tol);
        activation_input_n = 1'b0;
        cyc(10);
        check("ack in on-delay", direction_ack, 0);
        n = 0;
        while (direction_ack !== 1'b1 && n < 8)
        begin
            cyc(1);
            n++;
        end
        check("ack after on-delay", direction_ack, 1);
        // 3 sync edges, 2 ms of 4 cycles, then up to 5 cycles for the tick
        check("on-delay cycles", n >= 2 && n <= 6, 1);
        // model starts from the position taken as reference at monitoring start
        m_ax = ax;
        m_dir = dir;
        m_mo = mo;
        m_tol = tol;
        m_fault = 1'b0;
        m_pos = int'((ax != 0) ? pos.second_axis : pos.first_axis);
        m_ref = m_pos;
        // unselected axis runs backwards meanwhile
        step("permitted motion", s * 500);
        step("window edge", -s * tol);
        step("violation", -s);
        step("latched", s * 100);
        activation_input_n = 1'b1;
        cyc(8);
        check("ack released", direction_ack, 0);
        check("stop released", braking_stop_function, 0);
    endtask

    initial
    begin
        cyc(5);
        rst_n = 1'b1;
        cyc(4);
        // each combination of axis, direction and variant gets its own monitor pass
        for (int i = 0; i < 8; i++)
        begin
            run_pass(i & 1, (i >> 1) & 1, (i >> 2) & 1);
            $display("pass %0d done", i);
        end
        cfg.permanent = 1'b1;
        cyc(1);
        check("ack permanent at once", direction_ack, 1);
        cyc(11);
        check("ack permanent", direction_ack, 1);
        // last pass left second axis, positive direction, monitor-only variant
        m_fault = 1'b0;
        m_pos = int'(pos.second_axis);
        m_ref = m_pos;
        step("permanent violation", -m_tol - 1);
        cfg.permanent = 1'b0;
        cyc(8);
        check("ack inactive", direction_ack, 0);
        $display("permanent test done");
        report_and_stop();
    end

    // about eight times the expected run length
    initial
    begin
        cyc(5000);
        miscompares++;
        report_and_stop();
    end
endmodule // sdm_monitor_test
